// *** core/tiem_mapper.sv ***
/*
 * Telecontrol input event mapper: filters 16 inputs, keeps a millisecond
 * time base with clock sync, and hands out timestamped event objects.
 * Assumes a link layer that parses sync commands into one-cycle requests
 * and drains events with a ready signal; mode inputs are quasi-static.
 */
`timescale 1ns/100ps

// Operation
// - In the first protocol each input is a timed single-point object of type 30 addressed by its number 1 to 16.
// - Every accepted change of a reported input status raises a timestamped event.
// - In grouped first-protocol mode pairs are timed double-point objects of type 31 at the odd lower address.
// - First-protocol double points code 00 as intermediate, 01 as off and 10 as on.
// - A first-protocol sync of type 103 with cause 6 from the master loads the time base.
// - A first-protocol sync is taken at the broadcast link address as well as the own address.
// - In the second protocol each input is a type 1 message with function 253 and information number 1 to 16.
// - In grouped second-protocol mode pairs are type 1 messages with function 253 and the odd lower number.
// - Second-protocol pairs code 00 intermediate, 01 off, 10 on and 11 error.
// - A second-protocol sync with function 0 and cause 8 from the master updates the time base.
// - A periodic broadcast sync of the second protocol is adopted by every listening device.
// - Without a successful sync the free-running local time keeps stamping events.
// - A change is valid only after the input stays stable for its filter time, 50 ms by default.
module tiem_mapper #(
	parameter int TICK_CYCLES = tiem_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                  clk_sys_in,
	input  wire logic                  reset_n_in,
	// Raw input pins and filter setting
	input  tiem_pkg::tiem_inputs_t     pins_in,
	input  tiem_pkg::tiem_filter_cfg_t filter_ms_in,
	// Mode selection
	input  tiem_pkg::tiem_proto_t      protocol_sel_in,
	input  wire logic                  grouped_in,
	input  wire logic [15:0]           own_address_in,
	// Clock sync command from the link layer
	input  tiem_pkg::tiem_sync_cmd_t   sync_cmd_in,
	// Event output
	output tiem_pkg::tiem_event_t      event_out,
	output logic                       event_valid_out,
	input  wire logic                  event_ready_in,
	// Status
	output tiem_pkg::tiem_inputs_t     filtered_out,
	output tiem_pkg::tiem_time_t       local_time_out,
	output logic                       sync_ok_out
);
	import tiem_pkg::*;

	localparam tiem_inputs_t EVEN_MASK = 16'h5555;

	tiem_state_t  state;
	tiem_state_t  next_state;
	logic [31:0]  tick_count;
	logic         ms_tick;
	tiem_time_t   local_time;
	logic         sync_ok;
	logic         sync_load;
	tiem_inputs_t filt;
	tiem_inputs_t chg;
	tiem_inputs_t pend;
	tiem_inputs_t ent_set;
	tiem_inputs_t ent_clr;
	tiem_entry_t  entries [NUM_INPUTS];
	tiem_entry_t  ent_new [NUM_INPUTS];
	tiem_index_t  sel;
	logic         any;
	tiem_event_t  next_event;

	// Millisecond tick. A sync restarts the phase so the loaded time starts
	// a full millisecond before its first increment.
	wire tick_wrap = tick_count == 32'(TICK_CYCLES - 1);

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_count <= '0;
			ms_tick    <= 1'b0;
		end else begin
			tick_count <= (tick_wrap || sync_load) ? '0
			                                       : tick_count + 32'h0000_0001;
			ms_tick    <= tick_wrap && !sync_load;
		end
	end

	// Clock sync decode.
	wire is_first    = protocol_sel_in == PROTO_FIRST;
	wire addr_own    = sync_cmd_in.link_address == own_address_in;
	wire addr_bcast  = sync_cmd_in.link_address == BROADCAST_ADDR;
	wire addr_ok     = addr_own || addr_bcast;
	wire type_sync    = sync_cmd_in.type_identifier == TYPE_CLOCK_SYNC;
	wire func_sync    = sync_cmd_in.function_type == FUNC_SYNC;
	wire cause_first  = sync_cmd_in.transmission_cause == CAUSE_SYNC_FIRST;
	wire cause_second = sync_cmd_in.transmission_cause == CAUSE_SYNC_SECOND;
	wire sync_first   = is_first && type_sync && cause_first;
	wire sync_second  = !is_first && func_sync && cause_second;
	wire sync_kind    = is_first ? type_sync : func_sync;
	assign sync_load  = sync_cmd_in.valid && addr_ok
	                    && (sync_first || sync_second);
	// A sync-like command that is not taken leaves the time base running.
	wire sync_fail   = sync_cmd_in.valid && sync_kind && !sync_load;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			local_time <= '0;
			sync_ok    <= 1'b0;
		end else begin
			if (sync_load) begin
				local_time <= sync_cmd_in.time_ms;
			end else if (ms_tick) begin
				local_time <= local_time + 32'h0000_0001;
			end
			if (sync_load) begin
				sync_ok <= 1'b1;
			end else if (sync_fail) begin
				sync_ok <= 1'b0;
			end
		end
	end

	// Event selection: lowest pending entry first; in grouped mode only
	// the even entries, which hold the pairs, take part.
	wire tiem_inputs_t elig = grouped_in ? (pend & EVEN_MASK) : pend;
	wire               load = any
	                          && ((state == ST_IDLE) || event_ready_in);

	always_comb begin
		sel = '0;
		any = 1'b0;
		for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
			if (elig[i]) begin
				sel = tiem_index_t'(i);
				any = 1'b1;
			end
		end
	end

	// Per-input filter, pending flag and snapshot of value and time.
	for (genvar e = 0; e < NUM_INPUTS; e++) begin : g_entry
		logic [1:0] raw;
		logic [1:0] pair_code;
		logic       pair_set;
		logic       odd_drop;

		tiem_input_filter u_filter (
			.clk_sys_in   (clk_sys_in),
			.reset_n_in   (reset_n_in),
			.pin_in       (pins_in[e]),
			.ms_tick_in   (ms_tick),
			.filter_ms_in (filter_ms_in[e]),
			.state_out    (filt[e]),
			.change_out   (chg[e])
		);

		if (e % 2 == 0) begin : g_even
			assign raw      = {filt[e+1], filt[e]};
			assign pair_set = chg[e] | chg[e+1];
			assign odd_drop = 1'b0;
		end else begin : g_odd
			assign raw      = DP_INTERMEDIATE;
			assign pair_set = 1'b0;
			assign odd_drop = grouped_in;
		end

		// The first protocol has no error code; both inputs on reads as
		// intermediate there.
		assign pair_code = (is_first && (raw == DP_ERROR))
		                   ? DP_INTERMEDIATE : raw;
		assign ent_set[e] = grouped_in ? pair_set : chg[e];
		assign ent_clr[e] = (load && (sel == tiem_index_t'(e))) || odd_drop;
		assign ent_new[e].value = grouped_in ? pair_code
		                                     : {1'b0, filt[e]};
		assign ent_new[e].stamp = local_time;

		// A change in the cycle of its own hand-out stays pending.
		always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
			if (!reset_n_in) begin
				pend[e]    <= 1'b0;
				entries[e] <= '0;
			end else begin
				if (ent_set[e]) begin
					pend[e]    <= 1'b1;
					entries[e] <= ent_new[e];
				end else if (ent_clr[e]) begin
					pend[e]    <= 1'b0;
				end
			end
		end
	end

	// Event object fields.
	wire [15:0] ev_number = 16'(sel) + ADDR_BASE;
	wire [7:0]  type_first = grouped_in ? TYPE_DOUBLE_TIMED
	                                    : TYPE_SINGLE_TIMED;

	assign next_event.type_identifier    = is_first ? type_first
	                                                : TYPE_TIMETAGGED;
	assign next_event.object_address     = is_first ? ev_number : '0;
	assign next_event.function_type      = is_first ? FIELD_UNUSED
	                                                : FUNC_INPUTS;
	assign next_event.information_number = is_first ? FIELD_UNUSED
	                                                : ev_number[7:0];
	assign next_event.double_point_info  = entries[sel].value;
	assign next_event.timestamp          = entries[sel].stamp;

	// Output hand-off.
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (any) begin
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (event_ready_in && !any) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state     <= ST_IDLE;
			event_out <= '0;
		end else begin
			state <= next_state;
			if (load) begin
				event_out <= next_event;
			end
		end
	end

	assign event_valid_out = state == ST_HOLD;
	assign filtered_out    = filt;
	assign local_time_out  = local_time;
	assign sync_ok_out     = sync_ok;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	sequence load_first_single_s;
		load && is_first && !grouped_in;
	endsequence

	sequence load_first_pair_s;
		load && is_first && grouped_in;
	endsequence

	sequence load_second_single_s;
		load && !is_first && !grouped_in;
	endsequence

	sequence load_second_pair_s;
		load && !is_first && grouped_in;
	endsequence

	sequence sync_taken_s;
		sync_load;
	endsequence

	single_first_a: assert property (
		load_first_single_s |=>
		event_out.type_identifier == TYPE_SINGLE_TIMED
		&& event_out.object_address == 16'($past(sel)) + ADDR_BASE)
		else $error("Single-point object has wrong type or address.");

	double_first_a: assert property (
		load_first_pair_s |=>
		event_out.type_identifier == TYPE_DOUBLE_TIMED
		&& event_out.object_address[0] && event_out.object_address <= 16'h000F)
		else $error("Double-point object has wrong type or address.");

	code_first_a: assert property (
		load_first_pair_s |=> event_out.double_point_info != DP_ERROR)
		else $error("First protocol double point carries the error code.");

	single_second_a: assert property (
		load_second_single_s |=>
		event_out.type_identifier == TYPE_TIMETAGGED
		&& event_out.function_type == FUNC_INPUTS
		&& event_out.information_number == 8'($past(sel)) + 8'h01)
		else $error("Second protocol message has wrong fields.");

	pair_second_a: assert property (
		load_second_pair_s |=>
		event_out.type_identifier == TYPE_TIMETAGGED
		&& event_out.function_type == FUNC_INPUTS
		&& event_out.information_number[0])
		else $error("Second protocol pair has wrong fields.");

	pair_code_a: assert property (
		grouped_in && !is_first && chg[4] |=>
		entries[4].value == $past(filt[5:4]))
		else $error("Second protocol pair code not taken from inputs.");

	event_stamp_a: assert property (
		!grouped_in && chg[0] |=>
		pend[0] && entries[0].stamp == $past(local_time))
		else $error("Accepted change did not raise a stamped event.");

	sync_load_a: assert property (
		sync_taken_s |=> local_time == $past(sync_cmd_in.time_ms)
		&& sync_ok_out ##1 local_time == $past(local_time))
		else $error("Sync command did not load the time base.");

	free_run_a: assert property (
		sync_fail |=> !sync_ok_out
		&& (local_time - $past(local_time)) <= 32'h0000_0001)
		else $error("Failed sync disturbed the local time.");

	ms_count_a: assert property (
		ms_tick && !sync_load |=> local_time == $past(local_time) + 32'h0000_0001)
		else $error("Local time did not advance on the tick.");

	hold_event_a: assert property (
		event_valid_out && !event_ready_in |=>
		event_valid_out && $stable(event_out))
		else $error("Event changed while stalled.");

endmodule : tiem_mapper

// *** common/tiem_pkg.sv ***
/*
 * Shared constants and types of the telecontrol input event mapper.
 * Assumes a 40 MHz system clock and a link layer that frames the
 * telecontrol objects built here and parses incoming sync commands.
 */
package tiem_pkg;

	localparam int NUM_INPUTS     = 32'h0000_0010;
	localparam int CLK_FREQ_HZ    = 32'h0262_5A00;
	localparam int HZ_PER_MHZ     = 32'h000F_4240;
	localparam int TICK_PERIOD_US = 32'h0000_03E8;
	localparam int TICK_CYCLES    = CLK_FREQ_HZ / HZ_PER_MHZ * TICK_PERIOD_US;

	localparam logic [15:0] FILTER_MS_DEFAULT = 16'h0032;
	localparam logic [15:0] ADDR_BASE         = 16'h0001;
	localparam logic [15:0] BROADCAST_ADDR    = 16'hFFFF;

	localparam logic [7:0] TYPE_SINGLE_TIMED = 8'h1E;
	localparam logic [7:0] TYPE_DOUBLE_TIMED = 8'h1F;
	localparam logic [7:0] TYPE_CLOCK_SYNC   = 8'h67;
	localparam logic [7:0] CAUSE_SYNC_FIRST  = 8'h06;
	localparam logic [7:0] TYPE_TIMETAGGED   = 8'h01;
	localparam logic [7:0] FUNC_INPUTS       = 8'hFD;
	localparam logic [7:0] FUNC_SYNC         = 8'h00;
	localparam logic [7:0] CAUSE_SYNC_SECOND = 8'h08;
	localparam logic [7:0] FIELD_UNUSED      = 8'h00;

	localparam logic [1:0] DP_INTERMEDIATE = 2'h0;
	localparam logic [1:0] DP_OFF          = 2'h1;
	localparam logic [1:0] DP_ON           = 2'h2;
	localparam logic [1:0] DP_ERROR        = 2'h3;

	typedef logic [15:0] tiem_ms_t;
	typedef logic [31:0] tiem_time_t;
	typedef logic [3:0]  tiem_index_t;
	typedef logic [NUM_INPUTS-1:0] tiem_inputs_t;
	typedef logic [NUM_INPUTS-1:0][15:0] tiem_filter_cfg_t;

	typedef enum logic [1:0] {
		PROTO_FIRST  = 2'b01,
		PROTO_SECOND = 2'b10
	} tiem_proto_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_HOLD = 2'b10
	} tiem_state_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] type_identifier;
		logic [7:0] transmission_cause;
		logic [7:0] function_type;
		logic [15:0] link_address;
		tiem_time_t time_ms;
	} tiem_sync_cmd_t;

	typedef struct packed {
		logic [7:0]  type_identifier;
		logic [15:0] object_address;
		logic [7:0]  function_type;
		logic [7:0]  information_number;
		logic [1:0]  double_point_info;
		tiem_time_t  timestamp;
	} tiem_event_t;

	typedef struct packed {
		logic [1:0] value;
		tiem_time_t stamp;
	} tiem_entry_t;

endpackage : tiem_pkg

// *** core/tiem_input_filter.sv ***
/*
 * One input channel: three-stage synchroniser and stability filter.
 * Assumes a one-cycle millisecond tick from the parent block.
 */
`timescale 1ns/100ps
module tiem_input_filter (
	// Clock and reset
	input  wire logic           clk_sys_in,
	input  wire logic           reset_n_in,
	// Raw pin and timing
	input  wire logic           pin_in,
	input  wire logic           ms_tick_in,
	input  tiem_pkg::tiem_ms_t  filter_ms_in,
	// Filtered result
	output logic                state_out,
	output logic                change_out
);
	import tiem_pkg::*;

	logic     sync1;
	logic     sync2;
	logic     sync3;
	logic     level;
	tiem_ms_t stable_ms;

	// A zero setting selects the default filter time.
	wire tiem_ms_t limit   = (filter_ms_in == '0) ? FILTER_MS_DEFAULT
	                                                : filter_ms_in;
	wire           differs = level != state_out;
	// The first tick after a change comes after a partial millisecond, so
	// one tick more than the limit is needed to be sure of the full time.
	wire           accept  = differs && (stable_ms > limit);
	wire           at_top  = stable_ms == '1;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
			level <= 1'b0;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			sync3 <= sync2;
			if (sync2 == sync3) begin
				level <= sync3;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stable_ms  <= '0;
			state_out  <= 1'b0;
			change_out <= 1'b0;
		end else begin
			if (!differs) begin
				stable_ms <= '0;
			end else if (ms_tick_in && !at_top) begin
				stable_ms <= stable_ms + 16'h0001;
			end
			if (accept) begin
				state_out <= level;
			end
			change_out <= accept;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	filter_time_a: assert property (
		change_out |-> $past(stable_ms) > $past(limit))
		else $error("Filtered change before the filter time ran out.");

	filter_quiet_a: assert property (
		!differs |=> !change_out)
		else $error("Filtered change without a differing input level.");

endmodule : tiem_input_filter

// *** test/tiem_master_model.sv ***
/*
 * Master station model: issues clock sync commands and drains events.
 * Assumes the mapper samples on the rising edge; this model moves its
 * outputs on the falling edge, so nothing races the sampling edge.
 */
`timescale 1ns/100ps
module tiem_master_model (
	// Clock and reset
	input  wire logic                clk_sys_in,
	input  wire logic                reset_n_in,
	// Pacing of the event drain
	input  wire logic                slow_in,
	// Link side toward the mapper
	output tiem_pkg::tiem_sync_cmd_t sync_cmd_out,
	output logic                     event_ready_out
);
	import tiem_pkg::*;

	int seed = 32'h6fcb_0fe0;

	initial begin
		sync_cmd_out = '0;
		event_ready_out = 1'b0;
	end

	// A slow master accepts only about one cycle in four.
	always @(negedge clk_sys_in) begin
		event_ready_out <= reset_n_in && (!slow_in || ($random(seed) & 3) == 0);
	end

	// The command is a one-cycle pulse, taken at the rising edge inside it.
	task automatic send_sync(input logic [7:0] typ, cause, func,
		input logic [15:0] addr, input tiem_time_t t);
		@(negedge clk_sys_in);
		sync_cmd_out <= '{1'b1, typ, cause, func, addr, t};
		@(negedge clk_sys_in);
		sync_cmd_out.valid <= 1'b0;
		@(negedge clk_sys_in);
	endtask : send_sync

endmodule : tiem_master_model

// *** test/testbench.sv ***
/*
 * Self-checking bench of the input event mapper with a master model.
 * Assumes a short millisecond tick of four clocks and 2 ms filters,
 * except input 16 which keeps the default filter time.
 */
`timescale 1ns/100ps
`define CHK(a, e, m) begin tests_run++; \
	if ((a) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %0t %s", $time, m); end end
module testbench;
	import tiem_pkg::*;

	localparam int TICKS = 4;

	logic             clk_sys_in = 1'b0;
	logic             reset_n_in = 1'b0;
	tiem_inputs_t     pins = '0;
	tiem_filter_cfg_t fcfg;
	tiem_proto_t      proto = PROTO_FIRST;
	logic             grouped = 1'b0;
	logic             slow = 1'b0;
	logic [15:0]      own = 16'h0005;
	tiem_sync_cmd_t   sync_cmd;
	tiem_event_t      ev;
	logic             ev_valid;
	logic             ev_ready;
	tiem_inputs_t     filt;
	tiem_time_t       ltime;
	logic             sync_ok;
	tiem_time_t       t_ref;
	tiem_inputs_t     m;
	tiem_event_t      got[$];
	int               n_mismatch = 0;
	int               tests_run = 0;
	int               cycles = 0;
	int               seed = 32'h6fcb_0fe0;

	always #12.5 clk_sys_in = ~clk_sys_in;

	tiem_mapper #(.TICK_CYCLES(TICKS)) u_dut (
		.clk_sys_in      (clk_sys_in),
		.reset_n_in      (reset_n_in),
		.pins_in         (pins),
		.filter_ms_in    (fcfg),
		.protocol_sel_in (proto),
		.grouped_in      (grouped),
		.own_address_in  (own),
		.sync_cmd_in     (sync_cmd),
		.event_out       (ev),
		.event_valid_out (ev_valid),
		.event_ready_in  (ev_ready),
		.filtered_out    (filt),
		.local_time_out  (ltime),
		.sync_ok_out     (sync_ok)
	);

	tiem_master_model u_master (
		.clk_sys_in      (clk_sys_in),
		.reset_n_in      (reset_n_in),
		.slow_in         (slow),
		.sync_cmd_out    (sync_cmd),
		.event_ready_out (ev_ready)
	);

	always @(posedge clk_sys_in) begin
		if (reset_n_in && ev_valid === 1'b1 && ev_ready) begin
			got.push_back(ev);
		end
	end

	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	function automatic logic [1:0] exp_code(input logic lo, input logic hi);
		if (hi && lo) begin
			return (proto == PROTO_SECOND) ? 2'h3 : 2'h0;
		end
		return {hi, lo};
	endfunction : exp_code

	task automatic wait_ev(output tiem_event_t e);
		int n;
		n = 0;
		while (got.size() == 0 && n < 400) begin
			@(negedge clk_sys_in);
			n++;
		end
		`CHK(got.size() > 0, 1'b1, "no event")
		e = (got.size() > 0) ? got.pop_front() : '0;
	endtask : wait_ev

	task automatic chk_ev(input tiem_event_t e, input int k,
		input logic [1:0] code);
		logic p2;
		p2 = (proto == PROTO_SECOND);
		`CHK(e.type_identifier, p2 ? 8'h01 : (grouped ? 8'h1f : 8'h1e), "type")
		`CHK(e.object_address, p2 ? 16'h0000 : 16'(k + 1), "address")
		`CHK(e.function_type, p2 ? 8'hfd : 8'h00, "function")
		`CHK(e.information_number, p2 ? 8'(k + 1) : 8'h00, "number")
		`CHK(e.double_point_info, code, "value")
	endtask : chk_ev

	// Flips the masked inputs, then checks one event per flipped input.
	task automatic change(input tiem_inputs_t mask, input int quiet);
		tiem_time_t  t0;
		tiem_event_t e;
		int          k;
		@(negedge clk_sys_in);
		pins = pins ^ mask;
		t0 = ltime;
		if (quiet > 0) begin
			repeat (quiet) @(negedge clk_sys_in);
			`CHK(got.size(), 0, "early event")
		end
		for (int i = 0; i < 16; i++) begin
			if (mask[i]) begin
				wait_ev(e);
				k = grouped ? (i & 14) : i;
				chk_ev(e, k, grouped ? exp_code(pins[k], pins[k + 1])
					: {1'b0, pins[i]});
				`CHK(e.timestamp > t0 && e.timestamp <= ltime, 1'b1, "stamp")
				`CHK(filt[i], pins[i], "filtered state")
			end
		end
	endtask : change

	task automatic sync(input logic [7:0] typ, cause, func,
		input logic [15:0] a, input logic ok);
		tiem_time_t t;
		t = $random(seed);
		u_master.send_sync(typ, cause, func, a, t);
		if (ok) begin
			`CHK(ltime, t, "time not loaded")
		end else begin
			`CHK(ltime !== t, 1'b1, "time loaded")
		end
		`CHK(sync_ok, ok, "sync status")
	endtask : sync

	initial begin
		for (int i = 0; i < 16; i++) begin
			fcfg[i] = 16'h0002;
		end
		fcfg[15] = 16'h0000;
		repeat (20) @(negedge clk_sys_in);
		reset_n_in = 1'b1;
		@(negedge clk_sys_in);
		`CHK({ev_valid, sync_ok, ltime, filt}, 50'h0, "reset state")
		sync(8'h67, 8'h06, 8'h00, own, 1'b1);
		sync(8'h67, 8'h06, 8'h00, 16'hffff, 1'b1);
		sync(8'h67, 8'h08, 8'h00, own, 1'b0);
		sync(8'h67, 8'h06, 8'h00, 16'h0007, 1'b0);
		t_ref = ltime;
		repeat (40) @(negedge clk_sys_in);
		`CHK((ltime - t_ref) inside {[32'h0000_0009:32'h0000_000b]}, 1'b1, "free run")
		change(16'h0001, 0);
		slow = 1'b1;
		change(16'h0208, 0);
		@(negedge clk_sys_in);
		pins[2] = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		pins[2] = 1'b0;
		repeat (40) @(negedge clk_sys_in);
		`CHK(got.size(), 0, "glitch reported")
		change(16'h8000, 180);
		proto = PROTO_SECOND;
		sync(8'h00, 8'h08, 8'h00, own, 1'b1);
		sync(8'h00, 8'h08, 8'h00, 16'hffff, 1'b1);
		sync(8'h00, 8'h06, 8'h00, own, 1'b0);
		change(16'h4010, 0);
		grouped = 1'b1;
		for (int p = 0; p < 2; p++) begin
			proto = p ? PROTO_FIRST : PROTO_SECOND;
			repeat (2) begin
				change(16'h0010, 0);
				change(16'h0020, 0);
			end
			change(16'h8000, 0);
		end
		for (int r = 0; r < 24; r++) begin
			@(negedge clk_sys_in);
			proto = ($random(seed) & 1) ? PROTO_SECOND : PROTO_FIRST;
			grouped = ($random(seed) & 1) != 0;
			slow = ($random(seed) & 1) != 0;
			m = 16'h0001 << ({$random(seed)} % 16);
			if (!grouped) begin
				m = m | (16'h0001 << ({$random(seed)} % 16));
			end
			change(m, 0);
		end
		print_verdict();
	end

endmodule : testbench
